// ---- hw/cgc_top.sv ----
// Controller that writes and reads back three clock generator codes over a two-wire bus
// Contract
// - Code 1 disables, codes 2 to 12 pick frequencies, others leave setting unchanged.
// - Write trigger rising edge starts the serial transfer of the three codes at once.
// - Completion flag goes low at write start and stays low throughout.
// - Completion flag returns high when the write transfer finishes.
// - Read trigger rising edge starts read-back at once with completion flag low.
// - After a read, retrieved codes appear on the three read-back outputs.
// - Completion flag rises when the read ends, read-back outputs then valid.
// - Synchronous reset, low level resets, high level runs.
// - Completion flag zero means transfer in progress, one means complete.
// - Controller is bus master, drives serial clock and two-way serial data.
`timescale 1ns/10ps
`include "cgc_params.svh"

module cgc_top
    import cgc_pkg::*;
#(
    parameter int QUARTER_CYC = `CGC_QUARTER_CYC,
    parameter logic [6:0] DEV_ADDR = `CGC_DEV_ADDR
)
(
    input wire logic clk,
    input wire logic srst_n,
    input wire logic [3:0] gen_one_freq_code_in,
    input wire logic [3:0] gen_two_freq_code_in,
    input wire logic [3:0] gen_three_freq_code_in,
    input wire logic write_trigger,
    input wire logic read_trigger,
    output logic [3:0] gen_one_freq_code_out,
    output logic [3:0] gen_two_freq_code_out,
    output logic [3:0] gen_three_freq_code_out,
    output logic xfer_ready,
    output logic ack_error,
    output logic [2:0] code_applies,
    output logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    cgc_state_e state;
    cgc_codes_s tx_codes;
    cgc_bit_cmd_e bit_cmd;
    logic wr_prev;
    logic rd_prev;
    logic wr_rise;
    logic rd_rise;
    logic accept;
    logic op_read;
    logic launch;
    logic bit_wbit;
    logic bit_busy;
    logic bit_done;
    logic bit_rbit;
    logic sda_meta;
    logic sda_sync;
    logic [1:0] byte_idx;
    logic [2:0] bit_idx;
    logic [7:0] tx_byte;
    logic [15:0] rx_shift;
    logic reading_data;

    // Codes outside the documented range leave the generator as it was
    function automatic logic code_changes(input logic [3:0] code);
        return (code >= `CGC_CODE_DISABLE) && (code <= `CGC_CODE_LAST);
    endfunction

    // Open drain: the pin is only ever pulled low, the far end or the pull-up makes it high
    assign sda_out = 1'b0;

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end
        else
        begin
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
        end
        else
        begin
            wr_prev <= write_trigger;
            rd_prev <= read_trigger;
        end
    end

    assign wr_rise = write_trigger && !wr_prev;
    assign rd_rise = read_trigger && !rd_prev;
    // A write edge wins over a read edge seen in the same cycle
    assign accept = xfer_ready && (wr_rise || rd_rise);
    assign reading_data = op_read && (byte_idx != 2'h0);

    always_comb
    begin
        case (byte_idx)
            2'h0: tx_byte = {DEV_ADDR, op_read ? `CGC_RW_READ : `CGC_RW_WRITE};
            2'h1: tx_byte = {tx_codes.gen_one, tx_codes.gen_two};
            default: tx_byte = {tx_codes.gen_three, `CGC_PAD_NIBBLE};
        endcase
    end

    always_comb
    begin
        bit_cmd = BC_STOP;
        bit_wbit = 1'b1;
        case (state)
            ST_START: bit_cmd = BC_START;
            ST_BIT:
            begin
                bit_cmd = reading_data ? BC_READ : BC_WRITE;
                bit_wbit = tx_byte[bit_idx];
            end
            ST_ACK:
            begin
                // Master acknowledges read bytes except the last, which it refuses
                bit_cmd = reading_data ? BC_WRITE : BC_READ;
                bit_wbit = (byte_idx == `CGC_LAST_BYTE);
            end
            ST_STOP: bit_cmd = BC_STOP;
            default:
            begin
                bit_cmd = BC_STOP;
                bit_wbit = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            state <= ST_IDLE;
            launch <= 1'b0;
            byte_idx <= '0;
            bit_idx <= `CGC_MSB_BIT;
        end
        else
        begin
            launch <= 1'b0;
            case (state)
                ST_IDLE:
                    if (accept)
                    begin
                        state <= ST_START;
                        launch <= 1'b1;
                        byte_idx <= '0;
                        bit_idx <= `CGC_MSB_BIT;
                    end
                ST_START:
                    if (bit_done)
                    begin
                        state <= ST_BIT;
                        launch <= 1'b1;
                    end
                ST_BIT:
                    if (bit_done)
                    begin
                        launch <= 1'b1;
                        if (bit_idx == 3'h0)
                            state <= ST_ACK;
                        else
                            bit_idx <= bit_idx - 3'h1;
                    end
                ST_ACK:
                    if (bit_done)
                    begin
                        launch <= 1'b1;
                        bit_idx <= `CGC_MSB_BIT;
                        if (byte_idx == `CGC_LAST_BYTE)
                            state <= ST_STOP;
                        else
                        begin
                            byte_idx <= byte_idx + 2'h1;
                            state <= ST_BIT;
                        end
                    end
                ST_STOP:
                    if (bit_done)
                        state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            xfer_ready <= 1'b1;
            op_read <= 1'b0;
            tx_codes <= '0;
            code_applies <= '0;
        end
        else if (accept)
        begin
            xfer_ready <= 1'b0;
            op_read <= !wr_rise;
            if (wr_rise)
            begin
                // Codes are captured at the edge so a later change cannot corrupt the frame
                tx_codes <= '{gen_one_freq_code_in, gen_two_freq_code_in, gen_three_freq_code_in};
                code_applies <= {code_changes(gen_three_freq_code_in), code_changes(gen_two_freq_code_in),
                                 code_changes(gen_one_freq_code_in)};
            end
        end
        else if ((state == ST_STOP) && bit_done)
            xfer_ready <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            rx_shift <= '0;
            ack_error <= 1'b0;
            gen_one_freq_code_out <= '0;
            gen_two_freq_code_out <= '0;
            gen_three_freq_code_out <= '0;
        end
        else
        begin
            if (accept)
                ack_error <= 1'b0;
            else if ((state == ST_ACK) && !reading_data && bit_done && bit_rbit)
                ack_error <= 1'b1;
            if ((state == ST_BIT) && reading_data && bit_done)
                rx_shift <= {rx_shift[14:0], bit_rbit};
            if ((state == ST_STOP) && bit_done && op_read)
            begin
                gen_one_freq_code_out <= rx_shift[`CGC_RX_ONE];
                gen_two_freq_code_out <= rx_shift[`CGC_RX_TWO];
                gen_three_freq_code_out <= rx_shift[`CGC_RX_THREE];
            end
        end
    end

    cgc_bit_engine #(
        .QUARTER_CYC(QUARTER_CYC)
    ) u_bit_engine (
        .clk(clk),
        .srst_n(srst_n),
        .go(launch),
        .cmd(bit_cmd),
        .wbit(bit_wbit),
        .sda_in_sync(sda_sync),
        .busy(bit_busy),
        .done(bit_done),
        .rbit(bit_rbit),
        .scl(scl),
        .sda_oe(sda_oe)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!srst_n);

    sequence s_accept_write;
        xfer_ready && wr_rise;
    endsequence

    sequence s_accept_read;
        xfer_ready && rd_rise && !wr_rise;
    endsequence

    sequence s_stop_done;
        (state == ST_STOP) && bit_done;
    endsequence

    a_write_starts: assert property (s_accept_write |=> (state == ST_START) && launch && !op_read)
        else $error("write edge did not start a transfer");
    a_read_starts: assert property (s_accept_read |=> !xfer_ready && op_read && (state == ST_START))
        else $error("read edge did not start a read");
    a_busy_flag_low: assert property ((state != ST_IDLE) |-> !xfer_ready)
        else $error("completion flag high during a transfer");
    a_flag_returns: assert property (s_stop_done |=> xfer_ready && (state == ST_IDLE))
        else $error("completion flag did not return high");
    a_readback_valid: assert property (s_stop_done ##0 op_read |=>
        (gen_one_freq_code_out == $past(rx_shift[`CGC_RX_ONE])) &&
        (gen_three_freq_code_out == $past(rx_shift[`CGC_RX_THREE])))
        else $error("read-back outputs not updated after read");
    a_ignore_busy: assert property (!xfer_ready && (wr_rise || rd_rise) |=> $stable(tx_codes) && $stable(op_read))
        else $error("trigger accepted during a transfer");
    a_code_class: assert property (s_accept_write |=>
        code_applies[0] == ($past(gen_one_freq_code_in) inside {[`CGC_CODE_DISABLE:`CGC_CODE_LAST]}))
        else $error("code classification wrong");
    a_reset_state: assert property (@(posedge clk) disable iff (1'b0)
        !srst_n |=> xfer_ready && (state == ST_IDLE) && !sda_oe)
        else $error("reset did not bring the controller idle");
    a_flag_meaning: assert property (s_accept_write ##1 !xfer_ready[*8] |-> (state != ST_IDLE))
        else $error("flag low with no transfer in progress");

endmodule

// ---- hw/cgc_params.svh ----
// Constants for the clock generator serial configuration controller
`ifndef CGC_PARAMS_SVH
`define CGC_PARAMS_SVH

`define CGC_CLK_MHZ 40
`define CGC_T_QUARTER_NS 2500
`define CGC_QUARTER_CYC ((`CGC_T_QUARTER_NS * `CGC_CLK_MHZ + 999) / 1000)
`define CGC_DEV_ADDR 7'h50
`define CGC_RW_WRITE 1'b0
`define CGC_RW_READ 1'b1
`define CGC_LAST_BYTE 2'h2
`define CGC_MSB_BIT 3'h7
`define CGC_PAD_NIBBLE 4'h0
`define CGC_CODE_DISABLE 4'h1
`define CGC_CODE_FIRST 4'h2
`define CGC_CODE_LAST 4'hc
`define CGC_LAST_PHASE 2'h3
`define CGC_SAMPLE_PHASE 2'h2
`define CGC_RX_ONE 15:12
`define CGC_RX_TWO 11:8
`define CGC_RX_THREE 7:4

`endif

// ---- hw/cgc_pkg.sv ----
// Types shared by the clock generator configuration controller
package cgc_pkg;

    typedef enum logic [1:0] {BC_START, BC_STOP, BC_WRITE, BC_READ} cgc_bit_cmd_e;

    typedef enum {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP} cgc_state_e;

    typedef struct packed {
        logic [3:0] gen_one;
        logic [3:0] gen_two;
        logic [3:0] gen_three;
    } cgc_codes_s;

endpackage

// ---- hw/cgc_bit_engine.sv ----
// Serial bus bit engine: one start, stop, write or read bit per request
`timescale 1ns/10ps
`include "cgc_params.svh"

module cgc_bit_engine
    import cgc_pkg::*;
#(
    parameter int QUARTER_CYC = `CGC_QUARTER_CYC
)
(
    input wire logic clk,
    input wire logic srst_n,
    input wire logic go,
    input wire cgc_bit_cmd_e cmd,
    input wire logic wbit,
    input wire logic sda_in_sync,
    output logic busy,
    output logic done,
    output logic rbit,
    output logic scl,
    output logic sda_oe
);

    localparam int CW = $clog2(QUARTER_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(QUARTER_CYC - 1);

    logic [CW-1:0] cnt;
    logic [1:0] phase;
    cgc_bit_cmd_e cmd_q;
    logic wbit_q;
    logic next_scl;
    logic next_sda;
    logic tick;

    assign tick = busy && (cnt == CNT_LAST);

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            busy <= 1'b0;
            cnt <= '0;
            phase <= '0;
            cmd_q <= BC_STOP;
            wbit_q <= 1'b1;
        end
        else if (!busy && go)
        begin
            busy <= 1'b1;
            cnt <= '0;
            phase <= '0;
            cmd_q <= cmd;
            wbit_q <= wbit;
        end
        else if (tick)
        begin
            cnt <= '0;
            phase <= phase + 2'h1;
            if (phase == `CGC_LAST_PHASE)
                busy <= 1'b0;
        end
        else if (busy)
            cnt <= cnt + CW'(1);
    end

    // Start and stop change data only while the clock is high; data bits change only while it is low
    always_comb
    begin
        next_scl = 1'b1;
        next_sda = 1'b1;
        case (cmd_q)
            BC_START:
            begin
                next_scl = (phase != `CGC_LAST_PHASE);
                next_sda = (phase < `CGC_SAMPLE_PHASE);
            end
            BC_STOP:
            begin
                next_scl = (phase != 2'h0);
                next_sda = (phase >= `CGC_SAMPLE_PHASE);
            end
            BC_WRITE:
            begin
                next_scl = (phase == 2'h1) || (phase == `CGC_SAMPLE_PHASE);
                next_sda = wbit_q;
            end
            BC_READ:
            begin
                next_scl = (phase == 2'h1) || (phase == `CGC_SAMPLE_PHASE);
                next_sda = 1'b1;
            end
            default:
            begin
                next_scl = 1'b1;
                next_sda = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            scl <= 1'b1;
            sda_oe <= 1'b0;
        end
        else if (busy)
        begin
            scl <= next_scl;
            sda_oe <= !next_sda;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
        begin
            done <= 1'b0;
            rbit <= 1'b1;
        end
        else
        begin
            done <= tick && (phase == `CGC_LAST_PHASE);
            if (tick && (phase == `CGC_SAMPLE_PHASE))
                rbit <= sda_in_sync;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!srst_n);

    a_scl_idle_hold: assert property (!busy |=> $stable(scl))
        else $error("serial clock moved while the bit engine was idle");

endmodule

// ---- sim/cgc_companion_model.sv ----
// Behavioural companion device holding three generator codes on the two-wire bus
`timescale 1ns/10ps
module cgc_companion_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50
)
(
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    output logic pull
);
    logic [3:0] one = 4'h0;
    logic [3:0] two = 4'h0;
    logic [3:0] three = 4'h0;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx;
    logic active = 1'b0;
    logic rw = 1'b0;
    logic hit = 1'b0;
    int bcnt = 0;
    int bidx = 0;

    function automatic logic [3:0] keep(input logic [3:0] old, input logic [3:0] code);
        return (code >= 4'h1 && code <= 4'hc) ? code : old;
    endfunction

    initial pull = 1'b0;

    // Start and stop are data edges while the serial clock is high
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            active = 1'b1;
            bcnt = -1;
            bidx = 0;
        end

    always @(posedge sda)
        if (scl === 1'b1)
        begin
            active = 1'b0;
            pull = 1'b0;
        end

    always @(posedge scl)
        if (active && bcnt < 8)
            sh = {sh[6:0], sda};

    // Drive changes only while the clock is low so no false start or stop appears
    always @(negedge scl)
        if (active)
        begin
            bcnt++;
            if (bcnt == 9)
            begin
                bcnt = 0;
                bidx++;
            end
            pull = 1'b0;
            if (bcnt == 8)
            begin
                if (bidx == 0)
                begin
                    hit = (sh[7:1] == DEV_ADDR);
                    rw = sh[0];
                end
                else if (!rw && bidx == 1)
                begin
                    one = keep(one, sh[7:4]);
                    two = keep(two, sh[3:0]);
                end
                else if (!rw && bidx == 2)
                    three = keep(three, sh[7:4]);
                pull = hit && !nack && !(rw && bidx > 0);
            end
            // Once the master refuses the last byte the line stays released so its stop is seen
            else if (hit && rw && (bidx == 1 || bidx == 2))
            begin
                tx = (bidx == 1) ? {one, two} : {three, 4'ha};
                pull = ~tx[7 - bcnt];
            end
        end
endmodule

// ---- sim/cgc_top_tb_top.sv ----
// Self-checking bench for the clock generator configuration controller
`timescale 1ns/10ps
module cgc_top_tb_top;
    import cgc_pkg::*;
    localparam int Q = 2;
    logic clk = 1'b0;
    logic srst_n = 1'b0;
    logic wr_trig = 1'b0;
    logic rd_trig = 1'b0;
    logic nack = 1'b0;
    logic [3:0] c1 = 4'h0;
    logic [3:0] c2 = 4'h0;
    logic [3:0] c3 = 4'h0;
    logic [3:0] e1 = 4'h0;
    logic [3:0] e2 = 4'h0;
    logic [3:0] e3 = 4'h0;
    logic [3:0] o1, o2, o3;
    logic [2:0] applies;
    logic ready, ack_err, scl, sda_out, sda_oe, pull, sda;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int d;
    logic [11:0] rows [5] = '{12'h123, 12'h456, 12'h789, 12'habc, 12'h0df};

    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;

    cgc_top #(.QUARTER_CYC(Q)) DUT (.clk(clk), .srst_n(srst_n), .gen_one_freq_code_in(c1),
        .gen_two_freq_code_in(c2), .gen_three_freq_code_in(c3), .write_trigger(wr_trig),
        .read_trigger(rd_trig), .gen_one_freq_code_out(o1), .gen_two_freq_code_out(o2),
        .gen_three_freq_code_out(o3), .xfer_ready(ready), .ack_error(ack_err),
        .code_applies(applies), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));

    cgc_companion_model #(.DEV_ADDR(7'h50)) PEER (.scl(scl), .sda(sda), .nack(nack), .pull(pull));

    initial forever #12.5 clk = ~clk;

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_code(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic ok(input logic [3:0] c);
        return c >= 4'h1 && c <= 4'hc;
    endfunction

    // One transfer; poke raises the read trigger mid-frame
    task automatic run(input logic is_rd, input logic poke);
        if (is_rd)
            rd_trig = 1'b1;
        else
            wr_trig = 1'b1;
        repeat (2) @(negedge clk);
        chk_bit("ready_low", 1'b0, ready);
        wr_trig = 1'b0;
        rd_trig = 1'b0;
        d = 2;
        while (ready !== 1'b1 && d < 400)
        begin
            @(negedge clk);
            d++;
            if (poke && d == 50)
                rd_trig = 1'b1;
            if (poke && d == 53)
                rd_trig = 1'b0;
        end
        chk_bit("ready_high", 1'b1, ready);
        chk_bit("frame_len", 1'b1, d >= 255 && d < 300);
        chk_bit("scl_idle", 1'b1, scl);
    endtask

    task automatic write_codes(input logic [11:0] r, input logic poke);
        {c1, c2, c3} = r;
        run(1'b0, poke);
        chk_code("applies", {1'b0, ok(c3), ok(c2), ok(c1)}, {1'b0, applies});
        e1 = ok(c1) ? c1 : e1;
        e2 = ok(c2) ? c2 : e2;
        e3 = ok(c3) ? c3 : e3;
    endtask

    task automatic read_codes();
        run(1'b1, 1'b0);
        chk_code("gen_one", e1, o1);
        chk_code("gen_two", e2, o2);
        chk_code("gen_three", e3, o3);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            n_fail++;
            $display("Error timeout expected done seen hang");
            conclude();
        end
    end

    initial
    begin
        repeat (2) @(negedge clk);
        chk_bit("rst_ready", 1'b1, ready);
        chk_bit("rst_scl", 1'b1, scl);
        chk_bit("rst_oe", 1'b0, sda_oe);
        chk_code("rst_out", 4'h0, o1 | o2 | o3);
        srst_n = 1'b1;
        @(negedge clk);
        foreach (rows[i])
        begin
            write_codes(rows[i], 1'b0);
            chk_bit("ack_ok", 1'b0, ack_err);
            read_codes();
        end
        // A read edge in mid-write must be dropped, not queued
        write_codes(12'h567, 1'b1);
        repeat (6) @(negedge clk);
        chk_bit("ignored", 1'b1, ready);
        read_codes();
        nack = 1'b1;
        write_codes(12'h321, 1'b0);
        chk_bit("ack_err", 1'b1, ack_err);
        nack = 1'b0;
        read_codes();
        // Reset early in a frame stops it before any code reaches the device
        {c1, c2, c3} = 12'h999;
        wr_trig = 1'b1;
        repeat (12) @(negedge clk);
        wr_trig = 1'b0;
        srst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk_bit("mid_ready", 1'b1, ready);
        chk_bit("mid_scl", 1'b1, scl);
        srst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk_bit("rel_ready", 1'b1, ready);
        read_codes();
        conclude();
    end
endmodule
